// ==== core/fdc_param_cfg.svh ====
`ifndef FDC_PARAM_CFG_SVH
`define FDC_PARAM_CFG_SVH

// register byte addresses
`define ADDR_CTRL     8'h00
`define ADDR_CMD      8'h04
`define ADDR_LEN      8'h08
`define ADDR_SEEK     8'h0C
`define ADDR_PERP     8'h10
`define ADDR_PRECOMP  8'h14
`define ADDR_STATUS   8'h18
`define ADDR_RESULT   8'h1C
`define ADDR_GO       8'h20
`define ADDR_ACK      8'h24

// ctrl fields
`define CTRL_APD      0
`define CTRL_MINDLY   1
`define CTRL_OSC      2
`define CTRL_POLL     3
`define CTRL_WRITE_ENABLE_TIMING_CTL    4
`define CTRL_PTS_LSB  8
`define CTRL_PC_LSB   12
`define CTRL_SRST     31

// command fields
`define CMD_OP_LSB    0
`define CMD_MT        4
`define CMD_SK        5
`define CMD_NRP       6
`define CMD_ND        7
`define CMD_EC        8
`define CMD_HEAD      9
`define CMD_DRV_LSB   10
`define CMD_N_LSB     12
`define CMD_SEC_LSB   16
`define CMD_EOT_LSB   24

// length, seek and perpendicular fields
`define LEN_DTL_LSB   0
`define LEN_SC_LSB    8
`define SEEK_RCN_LSB  0
`define SEEK_DIR      8
`define SEEK_SRT_LSB  12
`define PERP_D_LSB    0
`define PERP_OW       7

// reset values
`define CTRL_RST      32'h0000_0000
`define CMD_RST       32'h0000_0000
`define LEN_RST       32'h0000_FF00
`define SEEK_RST      32'h0000_0000
`define PRECOMP_START_TRACK_RST    8'h00

// sizes and encodings
`define BASE_BYTES    15'h0080
`define FIRST_SECTOR  8'h01
`define RESULT_LAST   2'h3
`define ST0_SEEK_END  5

// timing, in ns
`define CLK_NS        8
`define PWRUP_SHORT_NS 10000000
`define PWRUP_LONG_NS  500000000
`define STEP_UNIT_NS  500000

`endif

// ==== core/fdc_param_pkg.sv ====
package fdc_param_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_READ_DEL,
    OP_WRITE,
    OP_FORMAT,
    OP_VERIFY,
    OP_SEEK_REL,
    OP_SENSE,
    OP_NOP
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WAKE,
    ST_DISPATCH,
    ST_SECTOR,
    ST_BYTE,
    ST_BYTE_GAP,
    ST_NEXT,
    ST_STEP,
    ST_STEP_GAP,
    ST_FINISH,
    ST_RESULT
  } state_t;

  typedef struct packed {
    op_t        op;
    logic       multi_track;
    logic       deleted_mark_bypass;
    logic       skip_result_phase;
    logic       host_transfer_mode;
    logic       verify_by_count;
    logic       head;
    logic [1:0] drive;
    logic [2:0] size_code;
    logic [7:0] start_sector;
    logic [7:0] last_sector;
    logic [7:0] short_sector_length;
    logic [7:0] sector_count;
    logic [7:0] relative_step_count;
    logic       step_in;
    logic [3:0] step_interval;
  } cmd_t;

endpackage

// ==== core/fdc_param.sv ====
`timescale 1ns/1ns
`include "fdc_param_cfg.svh"
module fdc_param #(
  parameter int unsigned PWRUP_SHORT_CYC = `PWRUP_SHORT_NS / `CLK_NS,
  parameter int unsigned PWRUP_LONG_CYC  = `PWRUP_LONG_NS / `CLK_NS,
  parameter int unsigned STEP_UNIT_CYC   = `STEP_UNIT_NS / `CLK_NS
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dack_n,
  input  wire logic        sector_deleted,
  output logic             drq,
  output logic             host_int,
  output logic             step,
  output logic             step_in,
  output logic             write_gate,
  output logic             pre_erase,
  output logic             precomp_active,
  output logic      [2:0]  precomp_sel,
  output logic             osc_enable,
  output logic             poll_enable,
  output logic             powered_down,
  output logic             head_sel
);

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [31:0]                 ctrl;
  logic [31:0]                 cmd_reg;
  logic [31:0]                 len_reg;
  logic [31:0]                 seek_reg;
  logic [1:0]                  perp_drives;
  logic [7:0]                  precomp_start_track;
  fdc_param_pkg::cmd_t         cmd;
  fdc_param_pkg::state_t       state;
  logic [7:0]                  head_cylinder_now;
  logic [7:0]                  sector_now;
  logic                        head_now;
  logic [7:0]                  sectors_done;
  logic [14:0]                 bytes_left;
  logic [7:0]                  steps_left;
  logic [31:0]                 wait_cnt;
  logic                        seek_end;
  logic [7:0]                  result_status_set [4];
  logic [1:0]                  res_idx;
  logic                        dack_s1;
  logic                        dack_s2;
  logic                        del_s1;
  logic                        del_s2;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `ADDR_CTRL, `ADDR_CMD, `ADDR_LEN, `ADDR_SEEK, `ADDR_PERP,
      `ADDR_PRECOMP, `ADDR_STATUS, `ADDR_RESULT, `ADDR_GO,
      `ADDR_ACK: mapped = 1'b1;
      default:   mapped = 1'b0;
    endcase
  endfunction

  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire setup   = psel & ~penable;
  wire wr_ctrl = wr & (paddr == `ADDR_CTRL);
  wire wr_cmd  = wr & (paddr == `ADDR_CMD);
  wire wr_len  = wr & (paddr == `ADDR_LEN);
  wire wr_seek = wr & (paddr == `ADDR_SEEK);
  wire wr_perp = wr & (paddr == `ADDR_PERP);
  wire wr_pre  = wr & (paddr == `ADDR_PRECOMP);
  wire wr_go   = wr & (paddr == `ADDR_GO);
  wire wr_ack  = wr & (paddr == `ADDR_ACK);
  wire in_res  = (state == fdc_param_pkg::ST_RESULT);
  wire rd_res  = access & ~pwrite & (paddr == `ADDR_RESULT) & in_res;
  wire soft_rst = ctrl[`CTRL_SRST];

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped(paddr);

  wire [31:0] status_word = {8'h00, sector_now, head_cylinder_now,
                             res_idx, in_res, powered_down, state};
  wire [31:0] result_word = in_res ? {24'h000000, result_status_set[res_idx]}
                                   : 32'h0000_0000;

  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `ADDR_CTRL:    rd_mux = ctrl;
      `ADDR_CMD:     rd_mux = cmd_reg;
      `ADDR_LEN:     rd_mux = len_reg;
      `ADDR_SEEK:    rd_mux = seek_reg;
      `ADDR_PERP:    rd_mux = {30'h0000_0000, perp_drives};
      `ADDR_PRECOMP: rd_mux = {24'h000000, precomp_start_track};
      `ADDR_STATUS:  rd_mux = status_word;
      `ADDR_RESULT:  rd_mux = result_word;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl                <= `CTRL_RST;
      cmd_reg             <= `CMD_RST;
      len_reg             <= `LEN_RST;
      seek_reg            <= `SEEK_RST;
      perp_drives         <= 2'h0;
      precomp_start_track <= `PRECOMP_START_TRACK_RST;
    end else begin
      if (wr_ctrl) ctrl <= pwdata;
      else if (soft_rst) ctrl[`CTRL_SRST] <= 1'b0;
      if (wr_cmd) cmd_reg <= pwdata;
      if (wr_len) len_reg <= pwdata;
      if (wr_seek) seek_reg <= pwdata;
      if (wr_perp && pwdata[`PERP_OW]) perp_drives <= pwdata[`PERP_D_LSB +: 2];
      if (wr_pre) precomp_start_track <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dack_s1 <= 1'b1;
      dack_s2 <= 1'b1;
      del_s1  <= 1'b0;
      del_s2  <= 1'b0;
    end else begin
      dack_s1 <= dack_n;
      dack_s2 <= dack_s1;
      del_s1  <= sector_deleted;
      del_s2  <= del_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode

  wire fdc_param_pkg::cmd_t new_cmd = '{
    op:                  fdc_param_pkg::op_t'(cmd_reg[`CMD_OP_LSB +: 3]),
    multi_track:         cmd_reg[`CMD_MT],
    deleted_mark_bypass: cmd_reg[`CMD_SK],
    skip_result_phase:   cmd_reg[`CMD_NRP],
    host_transfer_mode:  cmd_reg[`CMD_ND],
    verify_by_count:     cmd_reg[`CMD_EC],
    head:                cmd_reg[`CMD_HEAD],
    drive:               cmd_reg[`CMD_DRV_LSB +: 2],
    size_code:           cmd_reg[`CMD_N_LSB +: 3],
    start_sector:        cmd_reg[`CMD_SEC_LSB +: 8],
    last_sector:         cmd_reg[`CMD_EOT_LSB +: 8],
    short_sector_length: len_reg[`LEN_DTL_LSB +: 8],
    sector_count:        len_reg[`LEN_SC_LSB +: 8],
    relative_step_count: seek_reg[`SEEK_RCN_LSB +: 8],
    step_in:             seek_reg[`SEEK_DIR],
    step_interval:       seek_reg[`SEEK_SRT_LSB +: 4]
  };

  // a size code of zero means the short length governs, not 128
  wire [14:0] sector_bytes = (cmd.size_code == 3'h0)
                             ? {7'h00, cmd.short_sector_length}
                             : (`BASE_BYTES << cmd.size_code);

  wire is_read_data = (cmd.op == fdc_param_pkg::OP_READ);
  wire is_read_del  = (cmd.op == fdc_param_pkg::OP_READ_DEL);
  wire is_write     = (cmd.op == fdc_param_pkg::OP_WRITE) |
                      (cmd.op == fdc_param_pkg::OP_FORMAT);
  wire skip_sector  = cmd.deleted_mark_bypass &
                      ((is_read_data & del_s2) |
                       (is_read_del & ~del_s2));
  wire count_mode   = (cmd.op == fdc_param_pkg::OP_FORMAT) |
                      ((cmd.op == fdc_param_pkg::OP_VERIFY) & cmd.verify_by_count);
  wire last_sect    = count_mode ? (sectors_done + 8'h01 == cmd.sector_count)
                                 : (sector_now == cmd.last_sector);
  wire to_head1     = cmd.multi_track & ~head_now & ~count_mode;
  wire byte_ack     = cmd.host_transfer_mode ? wr_ack : ~dack_s2;
  wire apd_on       = ctrl[`CTRL_APD];
  wire [31:0] pwrup_cyc = ctrl[`CTRL_MINDLY] ? PWRUP_LONG_CYC : PWRUP_SHORT_CYC;
  wire [31:0] step_cyc  = STEP_UNIT_CYC * ({28'h000_0000, cmd.step_interval} + 32'h1);

  ////////////////////////////////////////////////////////////////////////
  // execution sequencer

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state             <= fdc_param_pkg::ST_IDLE;
      cmd               <= '0;
      head_cylinder_now <= 8'h00;
      sector_now        <= 8'h00;
      head_now          <= 1'b0;
      sectors_done      <= 8'h00;
      bytes_left        <= 15'h0000;
      steps_left        <= 8'h00;
      wait_cnt          <= 32'h0000_0000;
      seek_end          <= 1'b0;
      res_idx           <= 2'h0;
      powered_down      <= 1'b0;
      step              <= 1'b0;
      for (int i = 0; i < 4; i++) result_status_set[i] <= 8'h00;
    end else if (soft_rst) begin
      state        <= fdc_param_pkg::ST_IDLE;
      res_idx      <= 2'h0;
      powered_down <= 1'b0;
      step         <= 1'b0;
    end else begin
      step <= 1'b0;
      case (state)
        fdc_param_pkg::ST_IDLE: begin
          powered_down <= apd_on & ~wr_go;
          if (wr_go) begin
            cmd      <= new_cmd;
            seek_end <= 1'b0;
            wait_cnt <= 32'h0000_0000;
            state    <= (powered_down & apd_on) ? fdc_param_pkg::ST_WAKE
                                                : fdc_param_pkg::ST_DISPATCH;
          end
        end
        fdc_param_pkg::ST_WAKE: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (wait_cnt + 32'h1 >= pwrup_cyc) state <= fdc_param_pkg::ST_DISPATCH;
        end
        fdc_param_pkg::ST_DISPATCH: begin
          sector_now   <= cmd.start_sector;
          head_now     <= cmd.head;
          sectors_done <= 8'h00;
          steps_left   <= cmd.relative_step_count;
          case (cmd.op)
            fdc_param_pkg::OP_SEEK_REL: state <= fdc_param_pkg::ST_STEP;
            fdc_param_pkg::OP_SENSE:    state <= fdc_param_pkg::ST_FINISH;
            fdc_param_pkg::OP_NOP:      state <= fdc_param_pkg::ST_IDLE;
            default:                    state <= fdc_param_pkg::ST_SECTOR;
          endcase
        end
        fdc_param_pkg::ST_SECTOR: begin
          bytes_left <= sector_bytes;
          if (skip_sector || sector_bytes == 15'h0000) begin
            state <= fdc_param_pkg::ST_NEXT;
          end else begin
            state <= fdc_param_pkg::ST_BYTE;
          end
        end
        fdc_param_pkg::ST_BYTE: begin
          if (byte_ack) begin
            bytes_left <= bytes_left - 15'h0001;
            state      <= fdc_param_pkg::ST_BYTE_GAP;
          end
        end
        fdc_param_pkg::ST_BYTE_GAP: begin
          // one acknowledge counts one byte even if held for many cycles
          if (cmd.host_transfer_mode || dack_s2) begin
            state <= (bytes_left == 15'h0000) ? fdc_param_pkg::ST_NEXT
                                              : fdc_param_pkg::ST_BYTE;
          end
        end
        fdc_param_pkg::ST_NEXT: begin
          sectors_done <= sectors_done + 8'h01;
          if (!last_sect) begin
            sector_now <= sector_now + 8'h01;
            state      <= fdc_param_pkg::ST_SECTOR;
          end else if (to_head1) begin
            head_now   <= 1'b1;
            sector_now <= `FIRST_SECTOR;
            state      <= fdc_param_pkg::ST_SECTOR;
          end else begin
            state <= fdc_param_pkg::ST_FINISH;
          end
        end
        fdc_param_pkg::ST_STEP: begin
          if (steps_left == 8'h00) begin
            seek_end <= 1'b1;
            state    <= fdc_param_pkg::ST_FINISH;
          end else begin
            step              <= 1'b1;
            steps_left        <= steps_left - 8'h01;
            // offset is relative to where the head sits now
            head_cylinder_now <= cmd.step_in ? head_cylinder_now + 8'h01
                                             : head_cylinder_now - 8'h01;
            wait_cnt          <= 32'h0000_0000;
            state             <= fdc_param_pkg::ST_STEP_GAP;
          end
        end
        fdc_param_pkg::ST_STEP_GAP: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (wait_cnt + 32'h1 >= step_cyc) state <= fdc_param_pkg::ST_STEP;
        end
        fdc_param_pkg::ST_FINISH: begin
          result_status_set[0] <= {2'b00, seek_end, 2'b00, head_now, cmd.drive};
          result_status_set[1] <= 8'h00;
          result_status_set[2] <= 8'h00;
          result_status_set[3] <= head_cylinder_now;
          res_idx              <= 2'h0;
          state <= cmd.skip_result_phase ? fdc_param_pkg::ST_IDLE
                                         : fdc_param_pkg::ST_RESULT;
        end
        fdc_param_pkg::ST_RESULT: begin
          if (rd_res) begin
            res_idx <= res_idx + 2'h1;
            if (res_idx == `RESULT_LAST) state <= fdc_param_pkg::ST_IDLE;
          end
        end
        default: state <= fdc_param_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive side outputs

  wire in_byte   = (state == fdc_param_pkg::ST_BYTE);
  wire xfer_busy = (state == fdc_param_pkg::ST_SECTOR) | in_byte |
                   (state == fdc_param_pkg::ST_BYTE_GAP) |
                   (state == fdc_param_pkg::ST_NEXT);
  wire perp_sel  = ~cmd.drive[1] & perp_drives[cmd.drive[0]];
  wire [3:0] precomp_bypass = ctrl[`CTRL_PTS_LSB +: 4];

  assign drq      = in_byte & ~cmd.host_transfer_mode;
  assign host_int = in_byte & cmd.host_transfer_mode;

  // level outputs are registered so drive pins never glitch on decode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      step_in        <= 1'b0;
      write_gate     <= 1'b0;
      pre_erase      <= 1'b0;
      precomp_active <= 1'b0;
      precomp_sel    <= 3'h0;
      osc_enable     <= 1'b1;
      poll_enable    <= 1'b1;
      head_sel       <= 1'b0;
    end else begin
      step_in        <= cmd.step_in;
      write_gate     <= xfer_busy & is_write;
      // pre-erase heads need the gate opened ahead of the data field
      pre_erase      <= ctrl[`CTRL_WRITE_ENABLE_TIMING_CTL] & perp_sel & xfer_busy & is_write;
      precomp_active <= ~precomp_bypass[cmd.drive] &
                        (head_cylinder_now >= precomp_start_track);
      precomp_sel    <= precomp_bypass[cmd.drive] ? 3'h0 : ctrl[`CTRL_PC_LSB +: 3];
      osc_enable     <= ~ctrl[`CTRL_OSC];
      poll_enable    <= ~ctrl[`CTRL_POLL];
      head_sel       <= head_now;
    end
  end

endmodule

// ==== tb/fdc_param_props.sv ====
`timescale 1ns/1ns
`include "fdc_param_cfg.svh"
module fdc_param_props (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        dack_n,
  input wire logic        drq,
  input wire logic        host_int,
  input wire logic        step,
  input wire logic        write_gate,
  input wire logic        pre_erase,
  input wire logic [2:0]  precomp_sel,
  input wire logic        osc_enable,
  input wire logic        poll_enable,
  input wire logic        powered_down
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic ctrl_wr;
  logic ack_wr;
  logic go_wr;
  // soft reset writes are left out, though they clear only the reset bit of the control register
  assign ctrl_wr = psel && penable && pwrite && paddr == `ADDR_CTRL && !pwdata[`CTRL_SRST];
  assign ack_wr  = psel && penable && pwrite && paddr == `ADDR_ACK;
  assign go_wr   = psel && penable && pwrite && paddr == `ADDR_GO;
////////////////////////////////////////////////////////////////////////////////
  a_osc_follows: assert property (ctrl_wr |-> ##2 osc_enable == !$past(pwdata[2], 2))
    else $error("osc_enable off its control bit");
  a_poll_follows: assert property (ctrl_wr |-> ##2 poll_enable == !$past(pwdata[3], 2))
    else $error("poll_enable off its control bit");
  a_precomp_bypass: assert property (ctrl_wr && pwdata[11:8] == 4'hF |-> ##2 precomp_sel == 3'h0)
    else $error("precomp delay given while bypassed");
  a_step_single: assert property (step |=> !step [*3])
    else $error("step pulses too close");
  a_drq_ack: assert property ($fell(dack_n) && drq |-> ##[1:5] !drq)
    else $error("drq held after acknowledge");
  a_drq_rearm: assert property ($rose(dack_n) |-> !drq [*2])
    else $error("drq raised before acknowledge release seen");
  a_mode_excl: assert property (!(drq && host_int))
    else $error("drq and host_int together");
  a_int_ack: assert property (host_int && ack_wr |-> ##[1:2] !host_int)
    else $error("host_int held after host ack");
  a_wake_quiet: assert property (go_wr && powered_down |=> (!drq && !host_int) [*8])
    else $error("transfer before powerup time");
  a_erase_gate: assert property (pre_erase |-> write_gate)
    else $error("pre_erase outside write gate");
  cover property (drq && !dack_n);
  cover property (host_int && ack_wr);
  cover property (step ##1 !step);
endmodule
bind fdc_param fdc_param_props i_props (.mclk, .arst_n, .paddr, .psel, .penable, .pwrite,
  .pwdata, .dack_n, .drq, .host_int, .step, .write_gate, .pre_erase, .precomp_sel,
  .osc_enable, .poll_enable, .powered_down);

// ==== tb/dma_partner.sv ====
`timescale 1ns/1ns
module dma_partner (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       drq,
  input  wire logic [2:0] lag,
  output logic            dack_n,
  output int              acks
);
  int w;
  initial begin
    dack_n = 1'b1;
    acks = 0;
    forever begin
      @(posedge mclk);
      if (arst_n && drq === 1'b1) begin
        // arbitration delay of the controller is lag cycles before each byte's acknowledge
        for (w = 0; w < lag; w++) @(posedge mclk);
        dack_n <= 1'b0;
        while (drq === 1'b1) @(posedge mclk);
        dack_n <= 1'b1;
        acks++;
      end
    end
  end
endmodule

// ==== tb/fdc_command_parameter_logic_bench.sv ====
`timescale 1ns/1ns
`include "fdc_param_cfg.svh"
`define CHK(nm, ex, act) begin checked++; if ((ex) !== (act)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, act); end end
module fdc_command_parameter_logic_bench;
  logic        mclk, arst_n, psel, penable, pwrite, sector_deleted, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  lag, precomp_sel;
  logic        pready, pslverr, dack_n, drq, host_int, step, step_in, write_gate;
  logic        pre_erase, precomp_active, osc_enable, poll_enable, powered_down, head_sel;
  logic        go_mark;
  logic [7:0]  sc = 8'hFF;
  logic        got = 1'b0;
  logic        pe_seen = 1'b0;
  logic        hd_seen = 1'b0;
  logic [15:0] rnd = 16'hD28F;
  logic [7:0]  pw [3] = '{8'h83, 8'h00, 8'h82};
  logic [1:0]  pe [3] = '{2'h3, 2'h3, 2'h2};
  int          error_cnt, checked, acks, lat, steps, gap, last_gap, nb, i, ln;

  fdc_param #(.PWRUP_SHORT_CYC(10), .PWRUP_LONG_CYC(20), .STEP_UNIT_CYC(4)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dack_n(dack_n), .sector_deleted(sector_deleted), .drq(drq), .host_int(host_int),
    .step(step), .step_in(step_in), .write_gate(write_gate), .pre_erase(pre_erase),
    .precomp_active(precomp_active), .precomp_sel(precomp_sel), .osc_enable(osc_enable),
    .poll_enable(poll_enable), .powered_down(powered_down), .head_sel(head_sel));
  dma_partner i_dma (.mclk(mclk), .arst_n(arst_n), .drq(drq), .lag(lag), .dack_n(dack_n),
    .acks(acks));

  assign go_mark = psel && penable && pwrite && paddr == `ADDR_GO;
////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
  always @(posedge mclk) begin
    if (go_mark) begin
      lat <= 0;
      got <= 1'b0;
      pe_seen <= 1'b0;
      hd_seen <= 1'b0;
      steps <= 0;
    end else begin
      if (!got) lat <= lat + 1;
      got <= got | drq | host_int;
      pe_seen <= pe_seen | pre_erase;
      hd_seen <= hd_seen | head_sel;
      steps <= steps + int'(step);
      gap <= step ? 0 : gap + 1;
      if (step) last_gap <= gap;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // flag nibble is {host mode, skip result, deleted bypass, multi track}
  function automatic logic [31:0] cw(input logic [2:0] op, input logic [3:0] fl,
                                     input logic [2:0] n, input logic [7:0] s0, s1);
    return {s1, s0, 1'b0, n, 4'h0, fl, 1'b0, op};
  endfunction
  function automatic int eb(input int n, input int len, input int nsec);
    return (n == 0 ? len : (128 << n)) * nsec;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // starts a command and serves it until result phase or idle; ex < 0 skips the byte count
  task automatic run(input logic [31:0] cmd, input logic [31:0] sk, input int ex);
    int n;
    int a0;
    apb(1'b1, `ADDR_LEN, {16'h0000, sc, 8'(ln)});
    apb(1'b1, `ADDR_SEEK, sk);
    apb(1'b1, `ADDR_CMD, cmd);
    a0 = acks;
    nb = 0;
    apb(1'b1, `ADDR_GO, 32'h0);
    apb(1'b1, `ADDR_CMD, 32'hFFFF_FFFF);
    for (n = 0; n < 8000; n++) begin
      if (host_int === 1'b1) begin
        apb(1'b1, `ADDR_ACK, 32'h0);
        nb++;
      end
      apb(1'b0, `ADDR_STATUS, 32'h0);
      if (rd[5] === 1'b1 || rd[3:0] === fdc_param_pkg::ST_IDLE) break;
    end
    nb = nb + acks - a0;
    if (ex >= 0) `CHK("bytes", ex, nb)
  endtask
  task automatic results(input logic chk0, input logic [7:0] st0, input logic [7:0] cyl);
    int k;
    for (k = 0; k < 5; k++) begin
      apb(1'b0, `ADDR_RESULT, 32'h0);
      if (k != 0 || chk0) `CHK("result", {24'h0, (k == 0) ? st0 : (k == 3) ? cyl : 8'h00}, rd)
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, psel, penable, pwrite, sector_deleted} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lag = 3'h0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, `ADDR_CTRL, {17'h0, rnd[14:8], 3'h0, rnd[4:2], 2'h0});
      repeat (2) @(posedge mclk);
      `CHK("osc_enable", !rnd[2], osc_enable)
      `CHK("poll_enable", !rnd[3], poll_enable)
      `CHK("precomp_sel", rnd[8] ? 3'h0 : rnd[14:12], precomp_sel)
    end
    // every drive bypassed: no delay may be selected whatever the value field holds
    apb(1'b1, `ADDR_CTRL, 32'h0000_7F00);
    repeat (2) @(posedge mclk);
    `CHK("precomp_sel", 3'h0, precomp_sel)
    apb(1'b1, `ADDR_CTRL, 32'h0);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, `ADDR_PRECOMP, {24'h0, (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[7:0]});
      apb(1'b0, `ADDR_PRECOMP, 32'h0);
      `CHK("start_track", (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[7:0], rd[7:0])
      apb(1'b1, `ADDR_PERP, {24'h0, pw[i]});
      apb(1'b0, `ADDR_PERP, 32'h0);
      `CHK("perp_bits", pe[i], rd[1:0])
    end
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped_rd", 32'h0, rd)
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b1, `ADDR_CTRL, 32'h8000_0000);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    `CHK("soft_rst_clear", 32'h0, rd)
    // short sectors by DMA, then the four-byte result phase
    rnd = lfsr(rnd);
    ln = 1 + rnd[3:0];
    lag = rnd[6:4];
    run(cw(fdc_param_pkg::OP_READ, 4'h0, 3'h0, 8'h01, 8'h02), 32'h0, eb(0, ln, 2));
    results(1'b1, 8'h00, 8'h00);
    for (i = 1; i < 4; i++) begin
      lag = 3'(i * 3);
      run(cw(fdc_param_pkg::OP_READ, 4'h4, 3'(i), 8'h05, 8'h05), 32'h0, eb(i, 0, 1));
    end
    run(cw(fdc_param_pkg::OP_READ, 4'h5, 3'h0, 8'h01, 8'h02), 32'h0, eb(0, ln, 4));
    `CHK("head_one", 1'b1, hd_seen)
    results(1'b1, 8'h00, 8'h00);
    run(cw(fdc_param_pkg::OP_WRITE, 4'hC, 3'h0, 8'h03, 8'h04), 32'h0, eb(0, ln, 2));
    for (i = 0; i < 8; i++) begin
      sector_deleted <= i[1];
      run(cw(3'(i[0]), {2'h1, i[2], 1'b0}, 3'h0, 8'h01, 8'h02), 32'h0,
          (!i[2] || i[0] == i[1]) ? eb(0, ln, 2) : 0);
    end
    sector_deleted <= 1'b0;
    // count mode: format and verify-by-count stop on sector count, plain verify on last sector
    sc = 8'h03;
    run(cw(fdc_param_pkg::OP_FORMAT, 4'h4, 3'h0, 8'h01, 8'h01), 32'h0, eb(0, ln, 3));
    run(cw(fdc_param_pkg::OP_VERIFY, 4'h4, 3'h0, 8'h01, 8'h01) | 32'h0000_0100,
        32'h0, eb(0, ln, 3));
    run(cw(fdc_param_pkg::OP_VERIFY, 4'h4, 3'h0, 8'h01, 8'h01), 32'h0, eb(0, ln, 1));
    apb(1'b1, `ADDR_PERP, 32'h81);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `ADDR_CTRL, {27'h0, !i[0], 4'h0});
      run(cw(fdc_param_pkg::OP_WRITE, 4'h4, 3'h0, 8'h01, 8'h01), 32'h0, eb(0, ln, 1));
      `CHK("pre_erase", !i[0], pe_seen)
    end
    // relative seek in by three, then out by one, cylinder read back each time
    apb(1'b1, `ADDR_PRECOMP, 32'h0000_0003);
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      run(cw(fdc_param_pkg::OP_SEEK_REL, 4'h4, 3'h0, 8'h0, 8'h0),
          {18'h0, rnd[1:0], 3'h0, !i[0], (i == 0) ? 8'h03 : 8'h01}, -1);
      `CHK("steps", (i == 0) ? 3 : 1, steps)
      `CHK("step_in", !i[0], step_in)
      if (i == 0) `CHK("step_gap", 1'b1, last_gap + 1 == (rnd[1:0] + 1) * 4 ||
                       last_gap == (rnd[1:0] + 1) * 4)
      run(cw(fdc_param_pkg::OP_SENSE, 4'h0, 3'h0, 8'h0, 8'h0), 32'h0, -1);
      results(1'b1, 8'h00, (i == 0) ? 8'h03 : 8'h02);
      `CHK("precomp_active", !i[0], precomp_active)
    end
    for (i = 0; i < 3; i++) begin
      apb(1'b1, `ADDR_CTRL, {30'h0, i == 2, i != 0});
      repeat (4) @(posedge mclk);
      `CHK("powered_down", i != 0, powered_down)
      run(cw(fdc_param_pkg::OP_READ, 4'h4, 3'h0, 8'h01, 8'h01), 32'h0, eb(0, ln, 1));
      `CHK("wake_time", 1'b1, (i == 0) ? lat < 10 : lat >= ((i == 2) ? 20 : 10))
    end
    close_out();
  end
endmodule
